// >>> design/move_multiply_instr_exec.sv
`timescale 1ns/1ps
`default_nettype none
module move_multiply_instr_exec (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // fetch side
  input  wire logic [15:0] instr_word,
  input  wire logic        instr_valid,
  output logic             instr_take,
  output logic             instr_done,
  // register file read port
  output logic [7:0]       rd_addr,
  output logic             rd_en,
  input  wire logic [7:0]  rd_data,
  // register file write port
  output logic [7:0]       wr_addr,
  output logic [7:0]       wr_data,
  output logic             wr_en,
  // indirect pointers
  input  wire logic [7:0]  ptr0,
  input  wire logic [7:0]  ptr1,
  // status flag update
  output logic             zero_we,
  output logic             zero_val,
  // architectural state
  output logic [7:0]       bank_selector,
  output logic [7:0]       working_accumulator,
  output logic [7:0]       product_high_byte,
  output logic [7:0]       product_low_byte
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  mmx_pkg::quarter_e q_reg;
  mmx_pkg::op_e      op_reg;
  logic [15:0]       ir_reg;
  logic [7:0]        src_addr_reg;
  logic [7:0]        dst_addr_reg;
  logic [7:0]        data_reg;
  logic [15:0]       prod_next;
  logic              take_reg;
  logic              done_reg;
  logic [7:0]        rd_addr_reg;
  logic              rd_en_reg;
  logic [7:0]        wr_addr_reg;
  logic [7:0]        wr_data_reg;
  logic              wr_en_reg;
  logic              zero_we_reg;
  logic              zero_val_reg;
  logic [7:0]        bank_reg;
  logic [7:0]        acc_reg;
  logic [7:0]        prod_hi_reg;
  logic [7:0]        prod_lo_reg;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // only the fixed opcode bits are compared; u and x bits never matter
  function automatic mmx_pkg::op_e decode(input logic [15:0] w);
    if (w[15:8] == mmx_pkg::OPC_BANK_LO)
      return mmx_pkg::OP_BANK_LO;
    else if (w[15:9] == mmx_pkg::OPC_BANK_HI)
      return mmx_pkg::OP_BANK_HI;
    else if (w[15:8] == mmx_pkg::OPC_LIT_ACC)
      return mmx_pkg::OP_LIT_ACC;
    else if (w[15:13] == mmx_pkg::OPC_MOVE)
      return mmx_pkg::OP_MOVE;
    else if (w[15:8] == mmx_pkg::OPC_STORE)
      return mmx_pkg::OP_STORE;
    else if (w[15:8] == mmx_pkg::OPC_MUL)
      return mmx_pkg::OP_MUL;
    else
      return mmx_pkg::OP_NONE;
  endfunction

  // indirect locations stand for the address held in their pointer
  function automatic logic [7:0] resolve(input logic [7:0] a,
                                         input logic [7:0] p0,
                                         input logic [7:0] p1);
    if (a == mmx_pkg::INDIR0_ADDR)
      return p0;
    else if (a == mmx_pkg::INDIR1_ADDR)
      return p1;
    else
      return a;
  endfunction

  // ------------------------------------------------------------------
  // quarter sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      q_reg <= mmx_pkg::Q1;
    end else begin
      case (q_reg)
        mmx_pkg::Q1: q_reg <= mmx_pkg::Q2;
        mmx_pkg::Q2: q_reg <= mmx_pkg::Q3;
        mmx_pkg::Q3: q_reg <= mmx_pkg::Q4;
        mmx_pkg::Q4: q_reg <= mmx_pkg::Q1;
        default:     q_reg <= mmx_pkg::Q1;
      endcase
    end
  end

  // take strobe marks the cycle in which a word is accepted
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      take_reg <= 1'b1;
      done_reg <= 1'b0;
    end else begin
      take_reg <= (q_reg == mmx_pkg::Q4);
      done_reg <= (q_reg == mmx_pkg::Q4) && (op_reg != mmx_pkg::OP_NONE);
    end
  end

  // ------------------------------------------------------------------
  // decode (first quarter)
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      op_reg       <= mmx_pkg::OP_NONE;
      ir_reg       <= 16'h0000;
      src_addr_reg <= 8'h00;
      dst_addr_reg <= 8'h00;
    end else if (q_reg == mmx_pkg::Q1) begin
      ir_reg <= instr_word;
      op_reg <= instr_valid ? decode(instr_word) : mmx_pkg::OP_NONE;
      // window source field is five bits (00h to 1Fh); 00h and 08h then resolve to ptr0 and ptr1
      src_addr_reg <= resolve({3'b000, instr_word[12:8]},
                              ptr0, ptr1);
      dst_addr_reg <= resolve(instr_word[7:0], ptr0, ptr1);
    end
  end

  // ------------------------------------------------------------------
  // operand read (second quarter)
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rd_en_reg   <= 1'b0;
      rd_addr_reg <= 8'h00;
    end else begin
      // the accumulator is held here, so reading it needs no port cycle
      rd_en_reg   <= (q_reg == mmx_pkg::Q2) &&
                     (op_reg == mmx_pkg::OP_MOVE) &&
                     (src_addr_reg != mmx_pkg::ACC_ADDR);
      if (q_reg == mmx_pkg::Q2)
        rd_addr_reg <= src_addr_reg;
    end
  end

  // ------------------------------------------------------------------
  // process (third quarter)
  // ------------------------------------------------------------------
  // unsigned 8x8 always fits 16 bits, so no carry or overflow exists
  assign prod_next = 16'(acc_reg) * 16'(ir_reg[7:0]);

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      data_reg <= 8'h00;
    end else if (q_reg == mmx_pkg::Q3) begin
      if (src_addr_reg == mmx_pkg::ACC_ADDR)
        data_reg <= acc_reg;
      else
        data_reg <= rd_data;
    end
  end

  // ------------------------------------------------------------------
  // destination write (fourth quarter)
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      bank_reg <= mmx_pkg::BANK_RST;
    end else if (q_reg == mmx_pkg::Q4) begin
      if (op_reg == mmx_pkg::OP_BANK_LO)
        bank_reg[3:0] <= ir_reg[3:0];
      else if (op_reg == mmx_pkg::OP_BANK_HI)
        bank_reg[7:4] <= ir_reg[7:4];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      acc_reg <= mmx_pkg::ACC_RST;
    end else if (q_reg == mmx_pkg::Q4) begin
      if (op_reg == mmx_pkg::OP_LIT_ACC)
        acc_reg <= ir_reg[7:0];
      else if (op_reg == mmx_pkg::OP_MOVE &&
               dst_addr_reg == mmx_pkg::ACC_ADDR)
        acc_reg <= data_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      prod_hi_reg <= mmx_pkg::PROD_RST;
      prod_lo_reg <= mmx_pkg::PROD_RST;
    end else if (q_reg == mmx_pkg::Q4 && op_reg == mmx_pkg::OP_MUL) begin
      prod_hi_reg <= prod_next[15:8];
      prod_lo_reg <= prod_next[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      wr_en_reg   <= 1'b0;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
    end else begin
      wr_en_reg <= 1'b0;
      if (q_reg == mmx_pkg::Q4) begin
        if (op_reg == mmx_pkg::OP_MOVE &&
            dst_addr_reg != mmx_pkg::ACC_ADDR) begin
          wr_en_reg   <= 1'b1;
          wr_addr_reg <= dst_addr_reg;
          wr_data_reg <= data_reg;
        end else if (op_reg == mmx_pkg::OP_STORE) begin
          wr_en_reg   <= 1'b1;
          wr_addr_reg <= dst_addr_reg;
          wr_data_reg <= acc_reg;
        end
      end
    end
  end

  // only the move touches a flag; multiply never reports a zero product
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      zero_we_reg  <= 1'b0;
      zero_val_reg <= 1'b0;
    end else begin
      zero_we_reg <= (q_reg == mmx_pkg::Q4) &&
                     (op_reg == mmx_pkg::OP_MOVE);
      if (q_reg == mmx_pkg::Q4 && op_reg == mmx_pkg::OP_MOVE)
        zero_val_reg <= (data_reg == 8'h00);
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign instr_take          = take_reg;
  assign instr_done          = done_reg;
  assign rd_addr             = rd_addr_reg;
  assign rd_en               = rd_en_reg;
  assign wr_addr             = wr_addr_reg;
  assign wr_data             = wr_data_reg;
  assign wr_en               = wr_en_reg;
  assign zero_we             = zero_we_reg;
  assign zero_val            = zero_val_reg;
  assign bank_selector       = bank_reg;
  assign working_accumulator = acc_reg;
  assign product_high_byte   = prod_hi_reg;
  assign product_low_byte    = prod_lo_reg;

endmodule
`default_nettype wire

// >>> design/mmx_pkg.sv
// ----------------------------------------------------------------------
// Overview of operation
// - 1011_1000 loads bits 3:0 into bank selector low nibble; no flags.
// - unused encoding bits are ignored by decode; the bench sets some of them to one.
// - 1011_101x loads bits 7:4 into bank selector high nibble; no flags.
// - 1011_0000 loads the 8-bit literal into the accumulator; no flags.
// - 010 move copies window byte to data address, updates zero flag.
// - move destination spans 256 bytes, source spans locations 0 to 31.
// - move operands may be the accumulator; both resolve indirect pointers.
// - 0000_0001 stores the accumulator anywhere in data space; no flags.
// - 1011_1100 multiplies accumulator by literal, both unsigned 8-bit.
// - product high byte and low byte registers take the result.
// - multiply leaves every flag untouched, even on a zero product.
// ----------------------------------------------------------------------
package mmx_pkg;

  // ------------------------------------------------------------------
  // opcode fields
  // ------------------------------------------------------------------
  localparam logic [7:0] OPC_BANK_LO  = 8'h00_B8;
  localparam logic [6:0] OPC_BANK_HI  = 7'h00_5D;
  localparam logic [7:0] OPC_LIT_ACC  = 8'h00_B0;
  localparam logic [2:0] OPC_MOVE     = 3'h0_2;
  localparam logic [7:0] OPC_STORE    = 8'h00_01;
  localparam logic [7:0] OPC_MUL      = 8'h00_BC;

  // ------------------------------------------------------------------
  // special data addresses (placement chosen for this core)
  // ------------------------------------------------------------------
  localparam logic [7:0] ACC_ADDR     = 8'h00_0A;
  localparam logic [7:0] INDIR0_ADDR  = 8'h00_00;
  localparam logic [7:0] INDIR1_ADDR  = 8'h00_08;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] BANK_RST     = 8'h00_00;
  localparam logic [7:0] ACC_RST      = 8'h00_00;
  localparam logic [7:0] PROD_RST     = 8'h00_00;

  typedef enum logic [1:0] {Q1, Q2, Q3, Q4} quarter_e;

  typedef enum logic [2:0] {
    OP_NONE, OP_BANK_LO, OP_BANK_HI, OP_LIT_ACC, OP_MOVE, OP_STORE, OP_MUL
  } op_e;

endpackage

// >>> verification/move_multiply_instr_exec_chk.sv
`timescale 1ns/1ps
`default_nettype none
module move_multiply_instr_exec_chk (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        reset_n,
  // fetch side
  input wire logic [15:0] instr_word,
  input wire logic        instr_valid,
  input wire logic        instr_take,
  input wire logic        instr_done,
  // file ports and flag
  input wire logic [7:0]  rd_addr,
  input wire logic        rd_en,
  input wire logic [7:0]  wr_addr,
  input wire logic [7:0]  wr_data,
  input wire logic        wr_en,
  input wire logic        zero_we,
  input wire logic        zero_val,
  // state
  input wire logic [7:0]  bank_selector,
  input wire logic [7:0]  working_accumulator,
  input wire logic [7:0]  product_high_byte,
  input wire logic [7:0]  product_low_byte
);
  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire logic       tk = instr_take && instr_valid;
  wire logic [7:0] op = instr_word[15:8];

  a_take_period: assert property (
    instr_take |=> !instr_take [*3] ##1 instr_take)
    else $error("take spacing broken");
  a_bank_low: assert property (
    tk && op == mmx_pkg::OPC_BANK_LO |-> ##4 instr_done && !zero_we &&
    bank_selector == {$past(bank_selector[7:4], 4), $past(instr_word[3:0], 4)})
    else $error("bank low nibble load wrong");
  a_bank_high: assert property (
    tk && instr_word[15:9] == mmx_pkg::OPC_BANK_HI |-> ##4 !zero_we &&
    bank_selector == {$past(instr_word[7:4], 4), $past(bank_selector[3:0], 4)})
    else $error("bank high nibble load wrong");
  a_lit_load: assert property (
    tk && op == mmx_pkg::OPC_LIT_ACC |-> ##4 !zero_we &&
    working_accumulator == $past(instr_word[7:0], 4))
    else $error("literal load wrong");
  a_mul_product: assert property (
    tk && op == mmx_pkg::OPC_MUL |-> ##4 {product_high_byte, product_low_byte}
    == $past(working_accumulator, 4) * $past(instr_word[7:0], 4))
    else $error("product wrong");
  a_mul_quiet: assert property (
    tk && op == mmx_pkg::OPC_MUL |-> ##4 !zero_we && !wr_en &&
    working_accumulator == $past(working_accumulator, 4))
    else $error("multiply disturbed state");
  a_store_write: assert property (
    tk && op == mmx_pkg::OPC_STORE && instr_word[7:4] != 4'h0 |-> ##4 wr_en &&
    !zero_we && wr_addr == $past(instr_word[7:0], 4) &&
    wr_data == $past(working_accumulator, 4))
    else $error("store write wrong");
  a_move_read: assert property (
    tk && instr_word[15:13] == mmx_pkg::OPC_MOVE && instr_word[12] |->
    ##2 rd_en && rd_addr == {3'h0, $past(instr_word[12:8], 2)} ##2 zero_we)
    else $error("move read slot wrong");
  a_move_zero: assert property (
    wr_en && zero_we |-> zero_val == (wr_data == 8'h00))
    else $error("zero flag value wrong");

  c_mul: cover property (tk && op == mmx_pkg::OPC_MUL);
  c_move_zero: cover property (zero_we && zero_val);
  c_bank_high: cover property (tk && instr_word[15:9] == mmx_pkg::OPC_BANK_HI);
endmodule
bind move_multiply_instr_exec move_multiply_instr_exec_chk
  move_multiply_instr_exec_chk_i (.sys_clk, .reset_n, .instr_word,
  .instr_valid, .instr_take, .instr_done, .rd_addr, .rd_en, .wr_addr,
  .wr_data, .wr_en, .zero_we, .zero_val, .bank_selector, .working_accumulator,
  .product_high_byte, .product_low_byte);
`default_nettype wire

// >>> verification/move_multiply_instr_exec_bench.sv
`timescale 1ns/1ps
`default_nettype none
module move_multiply_instr_exec_bench;
  // ------------------------------------------------------------------
  // stimulus and observation
  // ------------------------------------------------------------------
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic        instr_valid = 1'b0;
  logic [7:0]  src_byte = 8'h00;
  logic [7:0]  ptr0 = 8'h00;
  logic [7:0]  ptr1 = 8'h00;
  logic [7:0]  rd_data, rd_addr, wr_addr, wr_data, bank_selector, rd_at;
  logic [7:0]  working_accumulator, product_high_byte, product_low_byte;
  logic        instr_take, instr_done, rd_en, wr_en, zero_we, zero_val;
  logic        rd_seen;
  int          n_fail = 0;
  int          checks = 0;
  always #5 sys_clk = ~sys_clk;
  // an idle read port shows the inverse, never the last byte
  assign rd_data = rd_en ? src_byte : ~src_byte;
  move_multiply_instr_exec move_multiply_instr_exec_i (.sys_clk, .reset_n,
    .instr_word, .instr_valid, .instr_take, .instr_done, .rd_addr, .rd_en,
    .rd_data, .wr_addr, .wr_data, .wr_en, .ptr0, .ptr1, .zero_we, .zero_val,
    .bank_selector, .working_accumulator, .product_high_byte,
    .product_low_byte);
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // issues one word at its take slot and returns in the next Q1 cycle
  task run(input logic [15:0] w, input logic v);
    while (instr_take !== 1'b1) @(negedge sys_clk);
    instr_word = w;
    instr_valid = v;
    @(negedge sys_clk);
    instr_valid = 1'b0;
    @(negedge sys_clk);
    rd_seen = rd_en;
    rd_at = rd_addr;
    repeat (2) @(negedge sys_clk);
  endtask
  task t_bank;
    run(16'hB8F5, 1'b1);
    chk({bank_selector, 7'h00, instr_done}, 16'h0501);
    run(16'hBB3F, 1'b1);
    chk({bank_selector, 7'h00, zero_we}, 16'h3500);
    run(16'hB809, 1'b1);
    chk({bank_selector, working_accumulator}, 16'h3900);
  endtask
  task t_lit_mul;
    run(16'hB0E2, 1'b1);
    chk({working_accumulator, 7'h00, zero_we}, 16'hE200);
    run(16'hBCC4, 1'b1);
    chk({product_high_byte, product_low_byte}, 16'h00E2 * 16'h00C4);
    chk({working_accumulator, 6'h00, zero_we, wr_en}, 16'hE200);
    run(16'hB000, 1'b1);
    run(16'hBCFF, 1'b1);
    chk({product_high_byte | product_low_byte, 7'h00, zero_we}, 16'h0000);
  endtask
  task t_store;
    run(16'hB04F, 1'b1);
    run(16'h01FF, 1'b1);
    chk({wr_addr, wr_data}, 16'hFF4F);
    chk({14'h0000, wr_en, zero_we}, 16'h0002);
    ptr0 = 8'h77;
    run(16'h0100, 1'b1);
    chk({wr_addr, wr_data}, 16'h774F);
  endtask
  task t_move;
    src_byte = 8'h00;
    run(16'h5FFF, 1'b1);
    chk({rd_at, 7'h00, rd_seen}, 16'h1F01);
    chk({wr_addr, wr_data}, 16'hFF00);
    chk({14'h0000, zero_we, zero_val}, 16'h0003);
    ptr1 = 8'h14;
    src_byte = 8'h3C;
    run(16'h480A, 1'b1);
    chk({rd_at, working_accumulator}, 16'h143C);
    chk({13'h0000, wr_en, zero_we, zero_val}, 16'h0002);
    run(16'h4A20, 1'b1);
    chk({wr_addr, wr_data}, 16'h203C);
    chk({15'h0000, rd_seen}, 16'h0000);
  endtask
  task t_refuse;
    run(16'hB011, 1'b0);
    chk({working_accumulator, 7'h00, instr_done}, 16'h3C00);
  endtask
  // ------------------------------------------------------------------
  // verdict, watchdog and main sequence
  // ------------------------------------------------------------------
  task test_done;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // about sixty cycles of work; the margin covers a stuck take
  initial begin
    #20000;
    n_fail++;
    test_done;
  end
  initial begin
    repeat (6) @(negedge sys_clk);
    reset_n = 1'b1;
    t_bank;
    t_lit_mul;
    t_store;
    t_move;
    t_refuse;
    test_done;
  end
endmodule
`default_nettype wire
